/* design/tmhbp_strobe.sv */
// Strobe sampler: qualifies read and write with chip select and makes event pulses.
`timescale 1ns/1ps
module tmhbp_strobe
(
    input  wire logic    clk,
    input  wire logic    rst,
    input  wire logic    cs_n,
    input  wire logic    rd_n,
    input  wire logic    wr_n,
    tmhbp_strobe_if.src  ev
);
    import tmhbp_pkg::*;

    logic rd_q;
    logic wr_q;
    logic rd_qq;
    logic wr_qq;

    // ====================================================================
    // Qualification
    wire rd_qual = ~cs_n & ~rd_n;
    wire wr_qual = ~cs_n & ~wr_n;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            rd_qq <= 1'b0;
            wr_qq <= 1'b0;
        end
        else
        begin
            rd_q  <= rd_qual;
            wr_q  <= wr_qual;
            rd_qq <= rd_q;
            wr_qq <= wr_q;
        end
    end

    // Start and end events are taken on the edges of the sampled strobes, one per pulse; the other outputs are levels.
    assign ev.rd_act   = rd_q;
    assign ev.rd_start = rd_q & ~rd_qq;
    assign ev.rd_end   = ~rd_q & rd_qq;
    assign ev.wr_end   = ~wr_q & wr_qq;
    assign ev.wr_live  = wr_qual;
    assign ev.cs_seen  = ~cs_n;
endmodule : tmhbp_strobe

/* design/tmhbp_top.sv */
// Host bus port of the five-counter timing controller.
`timescale 1ns/1ps
`include "tmhbp_map.svh"
module tmhbp_top
(
    input  wire logic                 CORE_CLK,
    input  wire logic                 SYS_RST,
    input  wire logic                 CS_N,
    input  wire logic                 RD_N,
    input  wire logic                 WR_N,
    input  wire logic                 CTRL_SEL,
    input  wire tmhbp_pkg::tmhbp_word_t DB_I,
    output logic [15:0]               DB_O,
    output logic [15:0]               DB_OE,
    input  wire tmhbp_pkg::tmhbp_byte_t STATUS_IN,
    output logic [7:0]                CMD,
    output logic                      CMD_STB,
    output logic [7:0]                DATA_PTR,
    output logic [15:0]               DP_WDATA,
    output logic                      DP_WR,
    output logic                      DP_RD,
    input  wire tmhbp_pkg::tmhbp_word_t DP_RDATA,
    output logic                      BUS_WIDTH_16,
    output logic                      POR_ACTIVE,
    output logic [4:0]                GATE_ENABLE
);
    import tmhbp_pkg::*;

    tmhbp_strobe_if ev ();

    tmhbp_phase_t phase;
    tmhbp_phase_t next_phase;
    tmhbp_word_t  db_hold;
    tmhbp_byte_t  lo_hold;
    tmhbp_byte_t  hi_hold;
    logic         bus_width_bit;
    logic         por;

    // ====================================================================
    // Strobe sampling
    tmhbp_strobe tmhbp_strobe_inst
    (
        .clk  (CORE_CLK),
        .rst  (SYS_RST),
        .cs_n (CS_N),
        .rd_n (RD_N),
        .wr_n (WR_N),
        .ev   (ev)
    );

    // ====================================================================
    // Decoding
    function automatic logic is_ptr_load(input tmhbp_byte_t b);
        is_ptr_load = (b & `TMHBP_PTR_CODE_MASK) == `TMHBP_PTR_CODE;
    endfunction : is_ptr_load

    wire ctrl_wr   = ev.wr_end & CTRL_SEL;
    wire data_wr   = ev.wr_end & ~CTRL_SEL;
    wire ptr_wr    = ctrl_wr & is_ptr_load(db_hold[7:0]);
    wire cmd_wr    = ctrl_wr & ~is_ptr_load(db_hold[7:0]);
    wire sw_reset  = cmd_wr & (db_hold[7:0] == `TMHBP_CMD_SW_RESET);
    wire go16      = cmd_wr & (db_hold[7:0] == `TMHBP_CMD_BUS16);
    wire go8       = cmd_wr & (db_hold[7:0] == `TMHBP_CMD_BUS8);
    wire ctrl_rd   = ev.rd_start & CTRL_SEL;
    wire data_rd   = ev.rd_start & ~CTRL_SEL;
    wire in_hi     = (phase == TMHBP_BYTE_HI);
    // In 8-bit mode a data word is two bus cycles, low byte first.
    wire word_wr   = data_wr & (bus_width_bit | in_hi);
    wire fetch_rd  = data_rd & (bus_width_bit | ~in_hi);
    wire step      = ~bus_width_bit & ((data_wr) | (ev.rd_end & ~CTRL_SEL));

    always_comb
    begin
        next_phase = phase;
        if (ctrl_wr | bus_width_bit)
        begin
            next_phase = TMHBP_BYTE_LO;
        end
        else if (step)
        begin
            case (phase)
                TMHBP_BYTE_LO: next_phase = TMHBP_BYTE_HI;
                TMHBP_BYTE_HI: next_phase = TMHBP_BYTE_LO;
                default:       next_phase = TMHBP_BYTE_LO;
            endcase
        end
    end

    // ====================================================================
    // Write data capture
    // The bus value is held from the last cycle of the strobe, because the
    // commit comes after the host has already released the lines.
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            db_hold <= `TMHBP_WORD_RST;
        end
        else if (ev.wr_live)
        begin
            db_hold <= DB_I;
        end
    end

    // ====================================================================
    // Control state
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            phase         <= TMHBP_BYTE_LO;
            bus_width_bit <= 1'b0;
            por           <= 1'b1;
            CMD           <= `TMHBP_CMD_RST;
            CMD_STB       <= 1'b0;
            DATA_PTR      <= `TMHBP_PTR_RST;
        end
        else
        begin
            phase   <= next_phase;
            CMD_STB <= cmd_wr;
            if (ev.cs_seen | sw_reset)
            begin
                por <= 1'b0;
            end
            if (cmd_wr)
            begin
                CMD <= db_hold[7:0];
            end
            if (ptr_wr)
            begin
                DATA_PTR <= db_hold[7:0] & `TMHBP_PTR_FIELD_MASK;
            end
            if (go16)
            begin
                bus_width_bit <= 1'b1;
            end
            else if (go8 | sw_reset)
            begin
                bus_width_bit <= 1'b0;
            end
        end
    end

    // ====================================================================
    // Data-port write path
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            DP_WDATA <= `TMHBP_WORD_RST;
            DP_WR    <= 1'b0;
            lo_hold  <= 8'h00;
        end
        else
        begin
            DP_WR <= word_wr;
            if (data_wr & ~bus_width_bit & ~in_hi)
            begin
                lo_hold <= db_hold[7:0];
            end
            if (word_wr)
            begin
                DP_WDATA <= bus_width_bit ? db_hold : {db_hold[7:0], lo_hold};
            end
        end
    end

    // ====================================================================
    // Read path
    // The pointed register is fetched once per word; in 8-bit mode the high
    // byte comes from a copy so that a counting register cannot tear.
    assign DP_RD = fetch_rd;

    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            DB_O    <= `TMHBP_WORD_RST;
            hi_hold <= 8'h00;
        end
        else if (ctrl_rd)
        begin
            DB_O <= {8'h00, STATUS_IN};
        end
        else if (fetch_rd)
        begin
            DB_O    <= bus_width_bit ? DP_RDATA : {8'h00, DP_RDATA[7:0]};
            hi_hold <= DP_RDATA[15:8];
        end
        else if (data_rd)
        begin
            DB_O <= {8'h00, hi_hold};
        end
    end

    // Upper lines are never driven in 8-bit mode.
    assign DB_OE = {{8{ev.rd_act & bus_width_bit}}, {8{ev.rd_act}}};

    // ====================================================================
    // Auxiliary gates
    // Gate lines are sampled on every cycle in 8-bit mode, because the host
    // holds them and the device never drives the upper lines in that mode.
    logic [4:0] aux_gate_input;

    genvar g;
    generate
        for (g = 0; g < `TMHBP_GATES; g = g + 1)
        begin : g_aux
            always_ff @(posedge CORE_CLK)
            begin
                if (SYS_RST)
                begin
                    aux_gate_input[g] <= 1'b1;
                end
                else if (bus_width_bit)
                begin
                    aux_gate_input[g] <= 1'b1;
                end
                else
                begin
                    aux_gate_input[g] <= DB_I[`TMHBP_GATE_LSB + g];
                end
            end
            assign GATE_ENABLE[g] = aux_gate_input[g];
        end
    endgenerate

    assign BUS_WIDTH_16 = bus_width_bit;
    assign POR_ACTIVE   = por;
endmodule : tmhbp_top

/* include/tmhbp_map.svh */
// Constants of the timer host bus port: codes, widths and reset values.
`ifndef TMHBP_MAP_SVH
`define TMHBP_MAP_SVH

// ====================================================================
// Widths
`define TMHBP_DATA_W      16
`define TMHBP_BYTE_W      8
`define TMHBP_PTR_W       8
`define TMHBP_GATES       5
`define TMHBP_GATE_LSB    8

// ====================================================================
// Control-port write decoding
`define TMHBP_PTR_CODE_MASK  8'hE0
`define TMHBP_PTR_CODE       8'h00
`define TMHBP_PTR_FIELD_MASK 8'h1F
`define TMHBP_CMD_BUS16      8'hEF
`define TMHBP_CMD_BUS8       8'hE7
`define TMHBP_CMD_SW_RESET   8'hFF

// ====================================================================
// Reset values
`define TMHBP_PTR_RST     8'h00
`define TMHBP_CMD_RST     8'h00
`define TMHBP_WORD_RST    16'h0000
`define TMHBP_GATE_RST    5'h1F

`endif

/* include/tmhbp_pkg.sv */
// Types shared by the timer host bus port modules.
package tmhbp_pkg;
    typedef enum logic [1:0]
    {
        TMHBP_BYTE_LO = 2'b00,
        TMHBP_BYTE_HI = 2'b01
    } tmhbp_phase_t;

    typedef logic [15:0] tmhbp_word_t;
    typedef logic [7:0]  tmhbp_byte_t;
endpackage : tmhbp_pkg

/* include/tmhbp_strobe_if.sv */
// Interface carrying qualified strobe events from the sampler to the port logic.
`timescale 1ns/1ps
interface tmhbp_strobe_if;
    logic rd_act;
    logic rd_start;
    logic rd_end;
    logic wr_end;
    logic wr_live;
    logic cs_seen;

    modport src
    (
        output rd_act,
        output rd_start,
        output rd_end,
        output wr_end,
        output wr_live,
        output cs_seen
    );
    modport dst
    (
        input rd_act,
        input rd_start,
        input rd_end,
        input wr_end,
        input wr_live,
        input cs_seen
    );
endinterface : tmhbp_strobe_if

/* test/tmhbp_chk.sv */
// Concurrent checks on the host bus port pins.
`timescale 1ns/1ps
module tmhbp_chk
(
    input wire logic        CORE_CLK,
    input wire logic        SYS_RST,
    input wire logic        CS_N,
    input wire logic        RD_N,
    input wire logic        CTRL_SEL,
    input wire logic [15:0] DB_OE,
    input wire logic [7:0]  CMD,
    input wire logic        CMD_STB,
    input wire logic        DP_WR,
    input wire logic        DP_RD,
    input wire logic        BUS_WIDTH_16,
    input wire logic        POR_ACTIVE,
    input wire logic [4:0]  GATE_ENABLE
);
    // ==========
    // Properties
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    idle_no_drive_a: assert property (CS_N [*2] |-> DB_OE == 16'h0000)
        else $error("data bus driven while deselected");
    idle_no_write_a: assert property (CS_N [*5] |-> !CMD_STB && !DP_WR)
        else $error("transfer while deselected");
    read_drive_a: assert property (!CS_N && !RD_N |=> DB_OE[7:0] == 8'hFF)
        else $error("read not driving low byte");
    upper_lines_a: assert property (DB_OE[15:8] != 8'h00 |-> BUS_WIDTH_16)
        else $error("upper lines driven in byte mode");
    gate_wide_a: assert property (BUS_WIDTH_16 && $past(BUS_WIDTH_16) |-> GATE_ENABLE == 5'h1F)
        else $error("gate inputs active in word mode");
    por_clear_a: assert property (!CS_N |-> ##[1:2] !POR_ACTIVE)
        else $error("power-on condition not cleared");
    por_hold_a: assert property (!POR_ACTIVE |=> !POR_ACTIVE)
        else $error("power-on condition came back");
    width_cmd_a: assert property ($rose(BUS_WIDTH_16) |-> CMD == 8'hEF)
        else $error("word mode without its command");
    cmd_kind_a: assert property (CMD_STB |-> !DP_WR && CMD[7:5] != 3'h0)
        else $error("pointer load seen as command");
    data_rd_port_a: assert property (DP_RD |-> !CTRL_SEL && !CS_N)
        else $error("data read outside data port");
endmodule : tmhbp_chk

bind tmhbp_top tmhbp_chk tmhbp_chk_inst
(
    .CORE_CLK(CORE_CLK),
    .SYS_RST(SYS_RST),
    .CS_N(CS_N),
    .RD_N(RD_N),
    .CTRL_SEL(CTRL_SEL),
    .DB_OE(DB_OE),
    .CMD(CMD),
    .CMD_STB(CMD_STB),
    .DP_WR(DP_WR),
    .DP_RD(DP_RD),
    .BUS_WIDTH_16(BUS_WIDTH_16),
    .POR_ACTIVE(POR_ACTIVE),
    .GATE_ENABLE(GATE_ENABLE)
);

/* test/tmhbp_host_bus.sv */
// Host side of the data bus: resolves the shared wire from both drivers.
`timescale 1ns/1ps
module tmhbp_host_bus
(
    input  wire logic                   clk,
    input  wire logic                   host_oe,
    input  wire tmhbp_pkg::tmhbp_word_t host_d,
    input  wire logic [4:0]             gates,
    input  wire logic                   wide,
    input  wire logic [15:0]            dev_d,
    input  wire logic [15:0]            dev_oe,
    output tmhbp_pkg::tmhbp_word_t      db
);
    import tmhbp_pkg::*;
    tmhbp_word_t last = 16'h0000;
    tmhbp_word_t host_w;
    tmhbp_word_t host_x;
    // A released line flips each cycle, except the upper byte in 8-bit mode (3'b111 and the gates), so stale data cannot pass for a fresh read.
    assign host_w = host_oe ? host_d : ~last;
    assign host_x = wide ? host_w : {3'b111, gates, host_w[7:0]};
    assign db = (dev_d & dev_oe) | (host_x & ~dev_oe);
    always_ff @(posedge clk) last <= db;
endmodule : tmhbp_host_bus

/* test/tmhbp_top_tb.sv */
// Self-checking bench for the host bus port.
`timescale 1ns/1ps
module tmhbp_top_tb;
    import tmhbp_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cs_n, rd_n, wr_n, ctrl, host_oe, wide, por, dp_wr;
    logic        cmd_stb, dp_rd;
    logic [4:0]  gates, gate_en;
    logic [7:0]  cmd, ptr;
    tmhbp_byte_t status;
    tmhbp_word_t host_d, dp_rdata, db;
    logic [15:0] db_o, db_oe, dp_wdata;
    int          err_count, n_tests, cycles, wr_cnt, rd_cnt, stb_cnt;

    tmhbp_top tmhbp_top_inst
    (
        .CORE_CLK(clk), .SYS_RST(rst), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
        .CTRL_SEL(ctrl), .DB_I(db), .DB_O(db_o), .DB_OE(db_oe), .STATUS_IN(status),
        .CMD(cmd), .CMD_STB(cmd_stb), .DATA_PTR(ptr), .DP_WDATA(dp_wdata), .DP_WR(dp_wr),
        .DP_RD(dp_rd), .DP_RDATA(dp_rdata), .BUS_WIDTH_16(wide), .POR_ACTIVE(por),
        .GATE_ENABLE(gate_en)
    );
    tmhbp_host_bus tmhbp_host_bus_inst
    (
        .clk(clk), .host_oe(host_oe), .host_d(host_d), .gates(gates), .wide(wide),
        .dev_d(db_o), .dev_oe(db_oe), .db(db)
    );

    // ==========
    // Clock and watchdog
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (dp_wr)
            wr_cnt <= wr_cnt + 1;
        if (dp_rd)
            rd_cnt <= rd_cnt + 1;
        if (cmd_stb)
            stb_cnt <= stb_cnt + 1;
        if (cycles == 2000)
        begin
            err_count++;
            test_done();
        end
    end

    // ==========
    // Tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic sel_n, input logic c, input tmhbp_word_t d);
        @(posedge clk);
        cs_n <= sel_n;
        wr_n <= 1'b0;
        ctrl <= c;
        host_d <= d;
        host_oe <= 1'b1;
        @(posedge clk);
        {cs_n, wr_n, host_oe} <= 3'b110;
        repeat (5) @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic c, input string what, input tmhbp_word_t exp);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        ctrl <= c;
        repeat (3) @(posedge clk);
        #1 chk(what, db, exp);
        @(posedge clk);
        {cs_n, rd_n} <= 2'b11;
        repeat (3) @(posedge clk);
        #1;
    endtask : rd

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    // ==========
    // Tests
    initial
    begin
        {cs_n, rd_n, wr_n, ctrl, host_oe} = 5'b11100;
        host_d = 16'h0000;
        gates = 5'h1F;
        status = 8'hA5;
        dp_rdata = 16'hBEEF;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk("por", por, 16'h0001);
        chk("width", wide, 16'h0000);
        chk("gates", gate_en, 16'h001F);
        $display("test reset done");
        wr(1'b1, 1'b1, 16'h0005);
        chk("ptr", ptr, 16'h0000);
        chk("por", por, 16'h0001);
        $display("test deselect done");
        rd(1'b1, "status", 16'hFFA5);
        chk("por", por, 16'h0000);
        chk("rcount", 16'(rd_cnt), 16'h0000);
        wr(1'b0, 1'b1, 16'h0005);
        chk("ptr", ptr, 16'h0005);
        chk("stbcount", 16'(stb_cnt), 16'h0000);
        wr(1'b0, 1'b1, 16'h0025);
        chk("cmd", cmd, 16'h0025);
        chk("stbcount", 16'(stb_cnt), 16'h0001);
        chk("ptr", ptr, 16'h0005);
        $display("test control done");
        wr(1'b0, 1'b0, 16'h0034);
        wr(1'b0, 1'b0, 16'h0012);
        chk("wdata", dp_wdata, 16'h1234);
        chk("wcount", 16'(wr_cnt), 16'h0001);
        rd(1'b0, "low", 16'hFFEF);
        rd(1'b0, "high", 16'hFFBE);
        chk("rcount", 16'(rd_cnt), 16'h0001);
        gates <= 5'h0A;
        repeat (3) @(posedge clk);
        #1 chk("gates", gate_en, 16'h000A);
        $display("test byte mode done");
        wr(1'b0, 1'b1, 16'h00EF);
        chk("width", wide, 16'h0001);
        chk("gates", gate_en, 16'h001F);
        wr(1'b0, 1'b0, 16'hC3A5);
        chk("wdata", dp_wdata, 16'hC3A5);
        chk("wcount", 16'(wr_cnt), 16'h0002);
        rd(1'b0, "word", 16'hBEEF);
        chk("rcount", 16'(rd_cnt), 16'h0002);
        wr(1'b0, 1'b1, 16'h00E7);
        chk("width", wide, 16'h0000);
        chk("gates", gate_en, 16'h000A);
        wr(1'b0, 1'b1, 16'h00EF);
        chk("width", wide, 16'h0001);
        wr(1'b0, 1'b1, 16'h00FF);
        chk("width", wide, 16'h0000);
        chk("cmd", cmd, 16'h00FF);
        chk("stbcount", 16'(stb_cnt), 16'h0005);
        $display("test word mode done");
        test_done();
    end
endmodule : tmhbp_top_tb
